// ==== pph_assertions.sv ====
// checker for the parallel port handshake block
`timescale 1ns/1ps
`default_nettype none
`include "pph_consts.svh"
module pph_chk (
	// clock and reset
	input wire logic	clk,
	input wire logic	rst_n,
	// register port
	input wire pph_pkg::pph_bus_s	bus,
	input wire logic [7:0]	rdata,
	// pins and drives
	input wire pph_pkg::pph_pins_s	pins,
	input wire logic [7:0]	port_a_out,
	input wire logic [7:0]	port_a_oe_n,
	input wire logic [7:0]	port_b_out,
	input wire logic [7:0]	port_b_oe_n,
	input wire logic	port_a_ctrl_io_out,
	input wire logic	port_a_ctrl_io_oe_n,
	input wire logic	port_b_ctrl_io_out,
	input wire logic	port_b_ctrl_io_oe_n,
	// interrupt
	input wire logic	irq_n
);
	logic [7:0]	mode;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// copy of the handshake mode register
	always_ff @(posedge clk)
		if (!rst_n)
			mode <= 8'h00;
		else if (bus.wr && bus.addr == `PPH_OFF_MODE)
			mode <= bus.wdata;
	chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> irq_n && &port_a_oe_n && &port_b_oe_n)
		else $error("drive after reset");
	chk_dir_drive: assert property (bus.wr && bus.addr == `PPH_OFF_DIR_A |=> ##1 port_a_oe_n == ~$past(bus.wdata, 2))
		else $error("direction not applied");
	chk_out_level: assert property (bus.wr && bus.addr == `PPH_OFF_DATA_B |=>
		##1 (port_b_out & ~port_b_oe_n) == ($past(bus.wdata, 2) & ~port_b_oe_n))
		else $error("output level wrong");
	chk_in_keep: assert property (bus.wr && bus.addr == `PPH_OFF_DATA_A_NH |=> ##1 $stable(port_a_oe_n))
		else $error("input line disturbed");
	chk_irq_off: assert property (bus.wr && bus.addr == `PPH_OFF_ENABLE && bus.wdata == 8'h0F |=> ##1 irq_n)
		else $error("irq while disabled");
	chk_pulse_one: assert property (mode[3:1] == `PPH_IO_PULSE && $fell(port_a_ctrl_io_out)
		&& !((bus.wr || bus.rd) && bus.addr == `PPH_OFF_DATA_A) |=> port_a_ctrl_io_out)
		else $error("pulse too long");
	chk_hs_low: assert property (mode[3:1] == `PPH_IO_HSHAKE && (bus.wr || bus.rd) && bus.addr == `PPH_OFF_DATA_A
		|=> ##[0:1] !port_a_ctrl_io_out)
		else $error("data taken missing");
	chk_b_ready: assert property (mode[7:5] == `PPH_IO_HSHAKE && bus.wr && bus.addr == `PPH_OFF_DATA_B
		|=> ##[0:1] !port_b_ctrl_io_out)
		else $error("data ready missing");
	chk_b_read: assert property (mode[7:5] == `PPH_IO_HSHAKE && bus.rd && bus.addr == `PPH_OFF_DATA_B
		&& port_b_ctrl_io_out |=> port_b_ctrl_io_out)
		else $error("read handshake on B");
	chk_io_fixed: assert property (mode[3:2] == 2'b11 |=> !port_a_ctrl_io_oe_n && port_a_ctrl_io_out == $past(mode[1]))
		else $error("fixed level wrong");
	chk_io_input: assert property (!mode[3] |=> port_a_ctrl_io_oe_n)
		else $error("input mode drives");
endmodule : pph_chk
bind pph_port pph_chk i_chk (
	.clk                 (clk),
	.rst_n               (rst_n),
	.bus                 (bus),
	.rdata               (rdata),
	.pins                (pins),
	.port_a_out          (port_a_out),
	.port_a_oe_n         (port_a_oe_n),
	.port_b_out          (port_b_out),
	.port_b_oe_n         (port_b_oe_n),
	.port_a_ctrl_io_out  (port_a_ctrl_io_out),
	.port_a_ctrl_io_oe_n (port_a_ctrl_io_oe_n),
	.port_b_ctrl_io_out  (port_b_ctrl_io_out),
	.port_b_ctrl_io_oe_n (port_b_ctrl_io_oe_n),
	.irq_n               (irq_n)
);
`default_nettype wire

// ==== pph_consts.svh ====
// constants for the parallel port handshake block
// Functional notes
// (R1) direction bit 0 input, 1 output
// (R2) output line follows output register bit
// (R3) output writes never disturb input lines
// (R4) port read returns input register
// (R5) latching off: port A input transparent
// (R6) latching on: capture A at edge
// (R7) read of latched A reopens transparency
// (R8) B outputs read stored bit; A pins
// (R9) aux control bits enable latching
// (R10) A handshakes read/write, B write only
// (R11) peripheral holds data until taken
// (R12) data ready sets control-in flag
// (R13) data taken pulse/level, low, released
// (R14) io line drives data ready, two modes
// (R15) data taken sets flag, drops ready
// (R16) peripheral returns data taken on ctrl in
// (R17) handshake mode register selects line modes
// (R18) flags set by events, held until serviced
// (R19) each flag has settable enable bit
// (R20) irq low when enabled flag set
// (R21) writing 1 clears flag bit
// (R22) flag bit 7 shows irq active
// (R23) reset clears registers: inputs, irq off
// (R24) control-in edge polarity is selectable
`ifndef PPH_CONSTS_SVH
`define PPH_CONSTS_SVH

`define PPH_AW            4
`define PPH_DW            8
`define PPH_OFF_DATA_B    4'h0
`define PPH_OFF_DATA_A    4'h1
`define PPH_OFF_DIR_B     4'h2
`define PPH_OFF_DIR_A     4'h3
`define PPH_OFF_AUX       4'h4
`define PPH_OFF_MODE      4'h5
`define PPH_OFF_FLAG      4'h6
`define PPH_OFF_ENABLE    4'h7
`define PPH_OFF_DATA_A_NH 4'h8
`define PPH_RST8          8'h00
`define PPH_RST4          4'h0
`define PPH_OE_OFF        8'hFF
`define PPH_NFLAG         4
`define PPH_IRQ_BIT       7
`define PPH_SET_BIT       7
// handshake mode register fields, per port
`define PPH_POL_A         0
`define PPH_MODE_A_LO     1
`define PPH_POL_B         4
`define PPH_MODE_B_LO     5
// control io mode codes
`define PPH_IO_HSHAKE     3'h4
`define PPH_IO_PULSE      3'h5
`define PPH_IO_LOW        3'h6
`define PPH_IO_HIGH       3'h7
`define PPH_IO_OUT_BIT    2
`define PPH_IO_POL_BIT    1
`define PPH_IO_INDEP_BIT  0

`endif

// ==== pph_peer.sv ====
// peripheral model on the port and control lines
`timescale 1ns/1ps
`default_nettype none
module pph_peer (
	// clock
	input wire logic	clk,
	// control io levels at the pins
	input wire logic	a_taken,
	input wire logic	b_ready,
	// lines driven by the peripheral
	output var logic [7:0]	pa,
	output var logic	ca1,
	output var logic	cb1
);
	logic	a_q = 1'b1;
	initial
	begin
		pa = 8'h00;
		ca1 = 1'b0;
		cb1 = 1'b0;
	end
	// data taken answers data ready low
	always @(posedge clk)
		cb1 <= ~b_ready;
	// data ready drops on data taken
	always @(posedge clk)
	begin
		a_q <= a_taken;
		if (a_q && !a_taken)
			ca1 <= 1'b0;
	end
	// new data only after the last was taken
	task automatic send(input logic [7:0] d);
		while (ca1)
			@(posedge clk);
		@(posedge clk);
		pa <= d;
		@(posedge clk);
		ca1 <= 1'b1;
	endtask : send
	// commanded early change of data
	task automatic put(input logic [7:0] d);
		@(posedge clk);
		pa <= d;
	endtask : put
endmodule : pph_peer
`default_nettype wire

// ==== pph_pkg.sv ====
// types for the parallel port handshake block
`default_nettype none
package pph_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pph_bus_s;

	typedef struct packed {
		logic [7:0] port_a;
		logic [7:0] port_b;
		logic       port_a_ctrl_in;
		logic       port_a_ctrl_io;
		logic       port_b_ctrl_in;
		logic       port_b_ctrl_io;
	} pph_pins_s;

	typedef logic [2:0] pph_io_mode_t;

endpackage : pph_pkg
`default_nettype wire

// ==== pph_port.sv ====
// two 8-bit ports with handshake control lines and interrupt flags
`timescale 1ns/1ps
`default_nettype none
`include "pph_consts.svh"
module pph_port #(
	parameter int NPORT = 2
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// register port
	input  wire pph_pkg::pph_bus_s bus,
	output var  logic [7:0]       rdata,
	// pins sampled from outside
	input  wire pph_pkg::pph_pins_s pins,
	// port A drive
	output var  logic [7:0]       port_a_out,
	output var  logic [7:0]       port_a_oe_n,
	// port B drive
	output var  logic [7:0]       port_b_out,
	output var  logic [7:0]       port_b_oe_n,
	// control io drive
	output var  logic             port_a_ctrl_io_out,
	output var  logic             port_a_ctrl_io_oe_n,
	output var  logic             port_b_ctrl_io_out,
	output var  logic             port_b_ctrl_io_oe_n,
	// interrupt request
	output var  logic             irq_n
);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic edge_seen(input logic prev, input logic cur, input logic pol);
		edge_seen = pol ? (~prev & cur) : (prev & ~cur);
	endfunction : edge_seen

	// two-stage synchroniser for all pins
	pph_pkg::pph_pins_s sync1;
	pph_pkg::pph_pins_s s;
	logic [1:0]         ctrl_in_prev;
	logic [1:0]         ctrl_io_prev;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync1 <= '0;
			s     <= '0;
		end
		else
		begin
			sync1 <= pins;
			s     <= sync1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_in_prev <= 2'h0;
			ctrl_io_prev <= 2'h0;
		end
		else
		begin
			ctrl_in_prev <= {s.port_b_ctrl_in, s.port_a_ctrl_in};
			ctrl_io_prev <= {s.port_b_ctrl_io, s.port_a_ctrl_io};
		end
	end

	// software registers
	logic [7:0] dir_a;
	logic [7:0] dir_b;
	logic [7:0] out_a;
	logic [7:0] out_b;
	logic [7:0] aux;
	logic [7:0] mode_reg;
	logic [3:0] flags;
	logic [3:0] enables;

	// bus decode
	logic wr_a;
	logic wr_b;
	logic rd_a;
	logic rd_a_nh;
	logic rd_b;
	logic wr_a_nh;

	assign wr_a    = bus.wr & hit(bus.addr, `PPH_OFF_DATA_A);
	assign wr_b    = bus.wr & hit(bus.addr, `PPH_OFF_DATA_B);
	assign rd_a    = bus.rd & hit(bus.addr, `PPH_OFF_DATA_A);
	assign rd_a_nh = bus.rd & hit(bus.addr, `PPH_OFF_DATA_A_NH);
	assign rd_b    = bus.rd & hit(bus.addr, `PPH_OFF_DATA_B);
	assign wr_a_nh = bus.wr & hit(bus.addr, `PPH_OFF_DATA_A_NH);

	// direction registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dir_a <= `PPH_RST8; // (R23)
			dir_b <= `PPH_RST8;
		end
		else if (bus.wr)
		begin
			if (hit(bus.addr, `PPH_OFF_DIR_A))
				dir_a <= bus.wdata;
			if (hit(bus.addr, `PPH_OFF_DIR_B))
				dir_b <= bus.wdata;
		end
	end

	// output registers, both port A data indices store the value
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			out_a <= `PPH_RST8;
			out_b <= `PPH_RST8;
		end
		else
		begin
			if (wr_a || wr_a_nh)
				out_a <= bus.wdata; // (R3)
			if (wr_b)
				out_b <= bus.wdata;
		end
	end

	// configuration registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aux      <= `PPH_RST8;
			mode_reg <= `PPH_RST8;
		end
		else if (bus.wr)
		begin
			if (hit(bus.addr, `PPH_OFF_AUX))
				aux <= bus.wdata; // (R9)
			if (hit(bus.addr, `PPH_OFF_MODE))
				mode_reg <= bus.wdata; // (R17)
		end
	end

	// per-port views
	logic [7:0]          pin_v [NPORT];
	logic [NPORT-1:0]    cin_pol;
	pph_pkg::pph_io_mode_t io_mode [NPORT];
	logic [NPORT-1:0]    cin_edge;
	logic [NPORT-1:0]    cio_edge;
	logic [NPORT-1:0]    hs_trig;
	logic [NPORT-1:0]    flag_acc;
	logic [NPORT-1:0]    port_rd;
	logic [7:0]          in_reg [NPORT];
	logic [NPORT-1:0]    io_q;
	logic [NPORT-1:0]    io_oe_n_q;
	logic [3:0]          flag_set;
	logic [3:0]          flag_clr;

	assign pin_v[0]   = s.port_a;
	assign pin_v[1]   = s.port_b;
	assign cin_pol[0] = mode_reg[`PPH_POL_A]; // (R24)
	assign cin_pol[1] = mode_reg[`PPH_POL_B];
	assign io_mode[0] = mode_reg[`PPH_MODE_A_LO +: 3];
	assign io_mode[1] = mode_reg[`PPH_MODE_B_LO +: 3];
	// port B control io only handshakes writes
	assign hs_trig[0] = rd_a | wr_a; // (R10)
	assign hs_trig[1] = wr_b;
	assign flag_acc[0] = rd_a | wr_a;
	assign flag_acc[1] = rd_b | wr_b;
	assign port_rd[0]  = rd_a | rd_a_nh;
	assign port_rd[1]  = rd_b;

	assign cin_edge[0] = edge_seen(ctrl_in_prev[0], s.port_a_ctrl_in, cin_pol[0]);
	assign cin_edge[1] = edge_seen(ctrl_in_prev[1], s.port_b_ctrl_in, cin_pol[1]);
	assign cio_edge[0] = edge_seen(ctrl_io_prev[0], s.port_a_ctrl_io, io_mode[0][`PPH_IO_POL_BIT]);
	assign cio_edge[1] = edge_seen(ctrl_io_prev[1], s.port_b_ctrl_io, io_mode[1][`PPH_IO_POL_BIT]);

	genvar k;
	generate
		for (k = 0; k < NPORT; k++)
		begin : g_port
			logic [7:0] held;
			logic       full;
			logic       io_is_out;

			assign io_is_out = io_mode[k][`PPH_IO_OUT_BIT];

			// input latch on control-in edge
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					held <= `PPH_RST8;
					full <= 1'b0;
				end
				else if (aux[k] && cin_edge[k])
				begin
					held <= pin_v[k]; // (R6)
					full <= 1'b1;
				end
				else if (port_rd[k])
					full <= 1'b0; // (R7)
			end

			assign in_reg[k] = full ? held : pin_v[k]; // (R5)

			// control io output
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					io_q[k]      <= 1'b1;
					io_oe_n_q[k] <= 1'b1;
				end
				else
				begin
					io_oe_n_q[k] <= ~io_is_out;
					unique case (io_mode[k])
						`PPH_IO_HSHAKE:
						begin
							if (cin_edge[k])
								io_q[k] <= 1'b1; // (R13) (R15)
							else if (hs_trig[k])
								io_q[k] <= 1'b0; // (R14)
						end
						`PPH_IO_PULSE:
							io_q[k] <= ~hs_trig[k]; // (R13) (R14)
						`PPH_IO_LOW:
							io_q[k] <= 1'b0;
						`PPH_IO_HIGH:
							io_q[k] <= 1'b1;
						default:
							io_q[k] <= 1'b1;
					endcase
				end
			end

			// flag events: ctrl in on odd bit, ctrl io on even bit
			assign flag_set[2*k+1] = cin_edge[k]; // (R12) (R15)
			assign flag_set[2*k]   = ~io_is_out & cio_edge[k];
			assign flag_clr[2*k+1] = flag_acc[k];
			assign flag_clr[2*k]   = flag_acc[k] & ~(~io_is_out & io_mode[k][`PPH_IO_INDEP_BIT]);
		end
	endgenerate

	// flag and enable registers
	logic       wr_flag;
	logic       wr_en;
	logic [3:0] flag_wclr;
	logic       irq_any;

	assign wr_flag   = bus.wr & hit(bus.addr, `PPH_OFF_FLAG);
	assign wr_en     = bus.wr & hit(bus.addr, `PPH_OFF_ENABLE);
	assign flag_wclr = wr_flag ? bus.wdata[3:0] : `PPH_RST4; // (R21)
	assign irq_any   = |(flags & enables); // (R20)

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			flags <= `PPH_RST4;
		else
			flags <= (flags & ~(flag_clr | flag_wclr)) | flag_set; // (R18)
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			enables <= `PPH_RST4; // (R23)
		else if (wr_en)
		begin
			if (bus.wdata[`PPH_SET_BIT])
				enables <= enables | bus.wdata[3:0]; // (R19)
			else
				enables <= enables & ~bus.wdata[3:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			irq_n <= 1'b1;
		else
			irq_n <= ~irq_any; // (R20)
	end

	// read data, one cycle after the strobe
	logic [7:0] next_rdata;

	always_comb
	begin
		next_rdata = `PPH_RST8;
		unique case (bus.addr)
			`PPH_OFF_DATA_A,
			`PPH_OFF_DATA_A_NH:
				next_rdata = in_reg[0]; // (R4) (R8)
			`PPH_OFF_DATA_B:
				next_rdata = (dir_b & out_b) | (~dir_b & in_reg[1]); // (R8)
			`PPH_OFF_DIR_A:
				next_rdata = dir_a;
			`PPH_OFF_DIR_B:
				next_rdata = dir_b;
			`PPH_OFF_AUX:
				next_rdata = aux;
			`PPH_OFF_MODE:
				next_rdata = mode_reg;
			`PPH_OFF_FLAG:
			begin
				next_rdata[3:0]          = flags;
				next_rdata[`PPH_IRQ_BIT] = irq_any; // (R22)
			end
			`PPH_OFF_ENABLE:
			begin
				next_rdata[3:0]          = enables;
				next_rdata[`PPH_SET_BIT] = 1'b1;
			end
			default:
				next_rdata = `PPH_RST8;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata <= `PPH_RST8;
		else if (bus.rd)
			rdata <= next_rdata;
		else
			rdata <= `PPH_RST8;
	end

	// pin drive
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			port_a_out  <= `PPH_RST8;
			port_b_out  <= `PPH_RST8;
			port_a_oe_n <= `PPH_OE_OFF;
			port_b_oe_n <= `PPH_OE_OFF;
		end
		else
		begin
			port_a_out  <= out_a; // (R2)
			port_b_out  <= out_b;
			port_a_oe_n <= ~dir_a; // (R1)
			port_b_oe_n <= ~dir_b;
		end
	end

	assign port_a_ctrl_io_out   = io_q[0];
	assign port_a_ctrl_io_oe_n  = io_oe_n_q[0];
	assign port_b_ctrl_io_out   = io_q[1];
	assign port_b_ctrl_io_oe_n  = io_oe_n_q[1];

endmodule : pph_port
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the parallel port handshake block
`timescale 1ns/1ps
`default_nettype none
`include "pph_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("FAIL %0t %h %h", $time, g, e); end end
module tb_top;
	logic	clk = 1'b0;
	logic	rst_n = 1'b0;
	pph_pkg::pph_bus_s	bus = '0;
	pph_pkg::pph_pins_s	pins;
	logic [7:0]	rdata, pa_out, pa_oe_n, pb_out, pb_oe_n, pa;
	logic	a_io, a_oe_n, b_io, b_oe_n, irq_n, ca1, cb1;
	int	fail_count = 0;
	int	n_checks = 0;
	int	cyc = 0;
	initial
		forever #10 clk = ~clk;
	assign pins.port_a = (pa_out & ~pa_oe_n) | (pa & pa_oe_n);
	assign pins.port_b = (pb_out & ~pb_oe_n) | (8'hC3 & pb_oe_n);
	assign pins.port_a_ctrl_in = ca1;
	assign pins.port_b_ctrl_in = cb1;
	assign pins.port_a_ctrl_io = a_oe_n | a_io;
	assign pins.port_b_ctrl_io = b_oe_n | b_io;
	pph_port i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .pins(pins), .port_a_out(pa_out),
		.port_a_oe_n(pa_oe_n), .port_b_out(pb_out), .port_b_oe_n(pb_oe_n), .port_a_ctrl_io_out(a_io),
		.port_a_ctrl_io_oe_n(a_oe_n), .port_b_ctrl_io_out(b_io), .port_b_ctrl_io_oe_n(b_oe_n), .irq_n(irq_n));
	pph_peer i_peer (.clk(clk), .a_taken(pins.port_a_ctrl_io), .b_ready(pins.port_b_ctrl_io),
		.pa(pa), .ca1(ca1), .cb1(cb1));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		tick(1);
		bus.wr <= 1'b0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		tick(1);
		bus.rd <= 1'b0;
		tick(1);
		`CHK(rdata, e)
	endtask : rd
	task automatic wait_io(input logic b, input logic v);
		for (int i = 0; i < 40 && (b ? b_io : a_io) !== v; i++)
			tick(1);
		`CHK(b ? b_io : a_io, v)
	endtask : wait_io
	task automatic end_sim();
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			fail_count++;
			end_sim();
		end
	end
	initial
	begin
		static logic [2:0] io_c [3] = '{`PPH_IO_LOW, `PPH_IO_HIGH, `PPH_IO_PULSE};
		static logic [1:0] io_e [3] = '{2'b00, 2'b01, 2'b01};
		tick(10);
		rst_n <= 1'b1;
		tick(1);
		for (logic [3:0] a = `PPH_OFF_DIR_B; a <= `PPH_OFF_FLAG; a++)
			rd(a, 8'h00);
		rd(`PPH_OFF_ENABLE, 8'h80);
		`CHK({pa_oe_n, pb_oe_n, irq_n}, 17'h1FFFF)
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		$display("reset test done");
		wr(`PPH_OFF_DIR_A, 8'h0F);
		wr(`PPH_OFF_DATA_A_NH, 8'hA5);
		i_peer.put(8'h3C);
		tick(3);
		`CHK({pa_oe_n, pa_out[3:0]}, 12'hF05)
		rd(`PPH_OFF_DATA_A_NH, 8'h35);
		wr(`PPH_OFF_DIR_B, 8'hF0);
		wr(`PPH_OFF_DATA_B, 8'h96);
		rd(`PPH_OFF_DATA_B, 8'h93);
		$display("port test done");
		wr(`PPH_OFF_DIR_A, 8'h00);
		wr(`PPH_OFF_AUX, 8'h01);
		wr(`PPH_OFF_MODE, 8'h09);
		wr(`PPH_OFF_ENABLE, 8'h82);
		i_peer.send(8'h11);
		tick(6);
		`CHK(irq_n, 1'b0)
		rd(`PPH_OFF_FLAG, 8'h82);
		i_peer.put(8'h33);
		tick(4);
		rd(`PPH_OFF_DATA_A, 8'h11);
		wait_io(1'b0, 1'b0);
		rd(`PPH_OFF_FLAG, 8'h00);
		rd(`PPH_OFF_DATA_A, 8'h33);
		i_peer.send(8'h22);
		wait_io(1'b0, 1'b1);
		tick(4);
		wr(`PPH_OFF_FLAG, 8'h02);
		rd(`PPH_OFF_FLAG, 8'h00);
		$display("read handshake test done");
		for (int i = 0; i < 3; i++)
		begin
			wr(`PPH_OFF_MODE, {4'h0, io_c[i], 1'b1});
			tick(2);
			`CHK({a_oe_n, a_io}, io_e[i])
		end
		wr(`PPH_OFF_DATA_A, 8'h00);
		wait_io(1'b0, 1'b0);
		tick(1);
		`CHK(a_io, 1'b1)
		wr(`PPH_OFF_MODE, 8'h99);
		wr(`PPH_OFF_ENABLE, 8'h88);
		wr(`PPH_OFF_DATA_B, 8'h5A);
		wait_io(1'b1, 1'b0);
		wait_io(1'b1, 1'b1);
		rd(`PPH_OFF_FLAG, 8'h88);
		tick(3);
		rd(`PPH_OFF_FLAG, 8'h88);
		wr(`PPH_OFF_ENABLE, 8'h0F);
		tick(2);
		`CHK(irq_n, 1'b1)
		rd(`PPH_OFF_FLAG, 8'h08);
		wr(`PPH_OFF_FLAG, 8'h08);
		rd(`PPH_OFF_FLAG, 8'h00);
		rd(`PPH_OFF_DATA_B, 8'h53);
		tick(2);
		`CHK(b_io, 1'b1)
		$display("write handshake test done");
		wr(`PPH_OFF_MODE, 8'h08);
		i_peer.send(8'h44);
		tick(6);
		rd(`PPH_OFF_FLAG, 8'h00);
		rd(`PPH_OFF_DATA_A, 8'h22);
		wait_io(1'b0, 1'b1);
		i_peer.put(8'h55);
		tick(4);
		rd(`PPH_OFF_FLAG, 8'h02);
		rd(`PPH_OFF_DATA_A_NH, 8'h44);
		$display("falling edge test done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
